// >>> logic/umr_misc_regs.sv
/*
 * Miscellaneous register bank of the USB peripheral: identity, frame number, scratch and unlock.
 * Assumes the bus strobes are synchronous single-cycle pulses, the SIE gives a one-cycle report
 * per error-free start-of-frame, and the suspend input is a level from the power logic.
 */
//
// Contract
// - identity register is read-only, fixed value
// - identity: part id 23:8, version 7:0
// - frame number updated on good SOF only
// - frame: count 10:0, microframe 13:11
// - 8-bit frame read: low byte first
// - 16-bit scratch, cleared by both resets
// - locked suspend ignores register writes except to unlock
// - writing AA37h re-enables register, FIFO writes
// - unlock write-only, bytes AAh and 37h
// - host-powered flag set: never lock
// - lock engages on suspend entry, flag clear
`timescale 1ns/1ps

module umr_misc_regs import umr_pkg::*; #(
    parameter logic [15:0] PART_ID = UMR_PART_ID_DEFAULT,  // arbitrary neutral value
    parameter logic [7:0] VERSION = UMR_VERSION_DEFAULT    // arbitrary neutral value
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic bus_reset_i,
    input wire logic suspend_i,
    input wire logic host_powered_flag_i,
    input wire umr_bus_req_type req_i,
    input wire umr_sof_type sof_i,
    output logic [23:0] rdata_o,
    output logic rvalid_o,
    output logic write_enable_o,
    output logic [15:0] scratch_o
);

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    function automatic logic umr_hit(input logic [7:0] a, input logic [7:0] ofs);
        // byte accesses to the high half sit at offset+1
        umr_hit = (a[7:2] == ofs[7:2]) && (a[1] == 1'b0);
    endfunction : umr_hit

    logic locked;
    logic suspend_q;
    logic frame_hi_pending;
    logic [15:0] frame_number;
    logic [15:0] firmware_scratch;

    wire hit_id = umr_hit(req_i.addr, UMR_OFS_IDENTITY);
    wire hit_frame = umr_hit(req_i.addr, UMR_OFS_FRAME);
    wire hit_scratch = umr_hit(req_i.addr, UMR_OFS_SCRATCH);
    wire hit_unlock = umr_hit(req_i.addr, UMR_OFS_UNLOCK);
    wire upper_byte = req_i.addr[0];
    wire [23:0] identity_word = {PART_ID, VERSION};
    wire suspend_entry = suspend_i && !suspend_q;
    wire lock_event = suspend_entry && !host_powered_flag_i;
    wire write_ok = req_i.wr && !locked;
    wire key_word = !req_i.byte_mode && (req_i.wdata == UMR_UNLOCK_KEY);
    wire key_high = req_i.byte_mode && upper_byte && (req_i.wdata[7:0] == UMR_UNLOCK_KEY_HIGH);
    wire key_low = req_i.byte_mode && !upper_byte && (req_i.wdata[7:0] == UMR_UNLOCK_KEY_LOW);
    logic key_low_seen;
    // byte-wide unlock needs the low byte then the high byte
    wire unlock_now = req_i.wr && hit_unlock && (key_word || (key_high && key_low_seen));
    wire scratch_wr = write_ok && hit_scratch;
    wire [15:0] next_scratch = !req_i.byte_mode ? req_i.wdata :
                               upper_byte ? {req_i.wdata[7:0], firmware_scratch[7:0]} :
                               {firmware_scratch[15:8], req_i.wdata[7:0]};
    wire [15:0] next_frame = {2'b00, sof_i.microframe_index, sof_i.frame_count};
    // byte read of frame: low first, then high from the same snapshot
    // either byte offset starts the pair with the low byte, so a stale snapshot never leaks
    wire frame_byte_hi = req_i.byte_mode && frame_hi_pending;
    logic [7:0] frame_hi_snap;
    wire [23:0] frame_read = !req_i.byte_mode ? {8'h00, frame_number} :
                             frame_byte_hi ? {16'h0000, frame_hi_snap} : {16'h0000, frame_number[7:0]};
    wire [15:0] scratch_read = !req_i.byte_mode ? firmware_scratch :
                               upper_byte ? {8'h00, firmware_scratch[15:8]} : {8'h00, firmware_scratch[7:0]};
    wire [23:0] id_read = !req_i.byte_mode ? identity_word :
                          upper_byte ? {16'h0000, identity_word[15:8]} : {16'h0000, identity_word[7:0]};
    // unlock and unmapped offsets read zero
    wire [23:0] next_rdata = hit_id ? id_read :
                             hit_frame ? frame_read :
                             hit_scratch ? {8'h00, scratch_read} : {8'h00, UMR_READ_RESET};

    // ------------------------------------------------------------------
    // write lock
    // ------------------------------------------------------------------
    // suspend entry wins over a same-cycle unlock so a floating strobe cannot undo it
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            locked <= 1'b0;
            suspend_q <= 1'b0;
            key_low_seen <= 1'b0;
        end else begin
            suspend_q <= suspend_i;
            if (lock_event) begin
                locked <= 1'b1;
            end else if (unlock_now) begin
                locked <= 1'b0;
            end
            if (req_i.wr && hit_unlock) begin
                key_low_seen <= key_low;
            end
        end
    end

    // ------------------------------------------------------------------
    // scratch register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            firmware_scratch <= UMR_SCRATCH_RESET;
        end else if (bus_reset_i) begin
            firmware_scratch <= UMR_SCRATCH_RESET;
        end else if (scratch_wr) begin
            firmware_scratch <= next_scratch;
        end
    end

    // ------------------------------------------------------------------
    // frame number capture
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            frame_number <= UMR_FRAME_RESET;
        end else if (bus_reset_i) begin
            frame_number <= UMR_FRAME_RESET;
        end else if (sof_i.valid) begin
            frame_number <= next_frame;
        end
    end

    // byte sequencer: the high byte is frozen when the low byte is read
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            frame_hi_pending <= 1'b0;
            frame_hi_snap <= 8'h00;
        end else if (req_i.rd && hit_frame && req_i.byte_mode) begin
            frame_hi_pending <= !frame_byte_hi;
            frame_hi_snap <= frame_byte_hi ? frame_hi_snap : frame_number[15:8];
        end else if (req_i.rd || req_i.wr) begin
            frame_hi_pending <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // outputs, all registered
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_o <= 24'h000000;
            rvalid_o <= 1'b0;
            write_enable_o <= 1'b1;
            scratch_o <= UMR_SCRATCH_RESET;
        end else begin
            rvalid_o <= req_i.rd;
            if (req_i.rd) begin
                rdata_o <= next_rdata;
            end
            // gates writes to other registers and the FIFOs elsewhere
            write_enable_o <= !(lock_event || (locked && !unlock_now));
            scratch_o <= firmware_scratch;
        end
    end

endmodule : umr_misc_regs

// >>> logic/umr_pkg.sv
/*
 * Package for the miscellaneous register bank: offsets, field layouts, reset values and
 * the types that carry the register bus and the start-of-frame report.
 * Assumes a byte-addressed register bus with 16-bit data, as the host parallel interface gives.
 */
package umr_pkg;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] UMR_OFS_IDENTITY = 8'h70;
    localparam logic [7:0] UMR_OFS_FRAME = 8'h74;
    localparam logic [7:0] UMR_OFS_SCRATCH = 8'h78;
    localparam logic [7:0] UMR_OFS_UNLOCK = 8'h7C;

    // ------------------------------------------------------------------
    // field layouts and values
    // ------------------------------------------------------------------
    localparam int UMR_FRAME_COUNT_W = 11;
    localparam int UMR_MICRO_W = 3;
    localparam int UMR_FRAME_COUNT_LSB = 0;
    localparam int UMR_MICRO_LSB = 11;
    localparam logic [15:0] UMR_UNLOCK_KEY = 16'hAA37;
    localparam logic [7:0] UMR_UNLOCK_KEY_HIGH = 8'hAA;
    localparam logic [7:0] UMR_UNLOCK_KEY_LOW = 8'h37;
    localparam logic [15:0] UMR_SCRATCH_RESET = 16'h0000;
    localparam logic [15:0] UMR_FRAME_RESET = 16'h0000;
    localparam logic [15:0] UMR_READ_RESET = 16'h0000;
    // identity defaults are arbitrary neutral values
    localparam logic [15:0] UMR_PART_ID_DEFAULT = 16'h5A5A;
    localparam logic [7:0] UMR_VERSION_DEFAULT = 8'h01;

    // ------------------------------------------------------------------
    // carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic rd;          // one-cycle read strobe
        logic wr;          // one-cycle write strobe
        logic byte_mode;   // 1: 8-bit access on data[7:0]
        logic [7:0] addr;
        logic [15:0] wdata;
    } umr_bus_req_type;

    typedef struct packed {
        logic valid;       // one-cycle: error-free start-of-frame seen
        logic [UMR_MICRO_W-1:0] microframe_index;
        logic [UMR_FRAME_COUNT_W-1:0] frame_count;
    } umr_sof_type;

endpackage : umr_pkg

// >>> verification/umr_misc_regs_sva.sv
/* checker for the misc register bank ports
   assumes one clock domain, reset low active */
`timescale 1ns/1ps
module umr_misc_regs_sva import umr_pkg::*; #(
    parameter logic [15:0] PART_ID = UMR_PART_ID_DEFAULT,
    parameter logic [7:0] VERSION = UMR_VERSION_DEFAULT
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic bus_reset_i,
    input wire logic suspend_i,
    input wire logic host_powered_flag_i,
    input wire umr_bus_req_type req_i,
    input wire umr_sof_type sof_i,
    input wire logic [23:0] rdata_o,
    input wire logic rvalid_o,
    input wire logic write_enable_o,
    input wire logic [15:0] scratch_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // word-wide decodes; byte writes follow their own pairing
    wire word_rd = req_i.rd && !req_i.byte_mode;
    wire key_wr = req_i.wr && !req_i.byte_mode && req_i.addr == UMR_OFS_UNLOCK;
    wire scr_wr = req_i.wr && !req_i.byte_mode && req_i.addr == UMR_OFS_SCRATCH && !bus_reset_i;
    rd_answer_a: assert property (req_i.rd |=> rvalid_o) else $error("read not answered");
    id_value_a: assert property (word_rd && req_i.addr == UMR_OFS_IDENTITY |=> rdata_o == {PART_ID, VERSION})
        else $error("identity wrong");
    lock_entry_a: assert property ($rose(suspend_i) && !host_powered_flag_i |=> !write_enable_o)
        else $error("no lock");
    powered_open_a: assert property (host_powered_flag_i && write_enable_o |=> write_enable_o)
        else $error("locked while powered");
    unlock_key_a: assert property (key_wr && req_i.wdata == UMR_UNLOCK_KEY && !$rose(suspend_i) |=> write_enable_o)
        else $error("key ignored");
    wrong_key_a: assert property (!write_enable_o && key_wr && req_i.wdata != UMR_UNLOCK_KEY |=> !write_enable_o)
        else $error("bad key unlocked");
    locked_drop_a: assert property (!write_enable_o && scr_wr |=> ##1 $stable(scratch_o))
        else $error("locked write landed");
    scratch_store_a: assert property (write_enable_o && scr_wr |=> ##1 scratch_o == $past(req_i.wdata, 2))
        else $error("scratch lost");
    bus_clear_a: assert property (bus_reset_i |=> ##1 scratch_o == UMR_SCRATCH_RESET)
        else $error("scratch kept");
    sof_latch_a: assert property (sof_i.valid && !bus_reset_i ##1 !sof_i.valid ##1 word_rd && req_i.addr == UMR_OFS_FRAME
        && !sof_i.valid && !bus_reset_i |=> rdata_o[15:0] == {2'b00, $past(sof_i[13:0], 3)})
        else $error("frame wrong");
    cover property ($rose(suspend_i) && !host_powered_flag_i);
    cover property (key_wr && !write_enable_o);
    cover property (req_i.rd && req_i.byte_mode && req_i.addr == 8'h75);
endmodule : umr_misc_regs_sva
bind umr_misc_regs umr_misc_regs_sva #(.PART_ID(PART_ID), .VERSION(VERSION)) u_sva (.clk_i(clk_i), .rstn_i(rstn_i),
    .bus_reset_i(bus_reset_i), .suspend_i(suspend_i), .host_powered_flag_i(host_powered_flag_i), .req_i(req_i),
    .sof_i(sof_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .write_enable_o(write_enable_o), .scratch_o(scratch_o));

// >>> verification/umr_fw_model.sv
/* firmware side of the register bus: one-cycle strobes
   assumes registered answers from the bank */
`timescale 1ns/1ps
module umr_fw_model import umr_pkg::*; (
    input wire logic clk_i,
    input wire logic rvalid_i,
    input wire logic [23:0] rdata_i,
    output umr_bus_req_type req_o
);
    initial req_o = '0;
    // idle fields inverted so a stale value never passes for a request
    task automatic do_wr(input logic [7:0] a, input logic [15:0] d, input logic bm);
        @(posedge clk_i);
        req_o <= '{1'b0, 1'b1, bm, a, d};
        @(posedge clk_i);
        req_o <= '{1'b0, 1'b0, bm, ~a, ~d};
    endtask : do_wr
    task automatic do_rd(input logic [7:0] a, input logic bm, output logic [23:0] d, output bit ok);
        ok = 1'b0;
        @(posedge clk_i);
        req_o <= '{1'b1, 1'b0, bm, a, ~req_o.wdata};
        @(posedge clk_i);
        req_o.rd <= 1'b0;
        // the answer stands for the single cycle after the strobe edge
        for (int i = 0; i < 4 && !ok; i++) begin
            #1 ok = (rvalid_i === 1'b1);
            d = rdata_i;
            if (!ok) @(posedge clk_i);
        end
    endtask : do_rd
endmodule : umr_fw_model

// >>> verification/tb_usb_peripheral_misc_regs.sv
/* self-checking bench for the misc register bank
   assumes the firmware model owns the bus; sof and power levels come from here */
`timescale 1ns/1ps
module tb_usb_peripheral_misc_regs import umr_pkg::*;;
    logic clk_i = 1'b0, rstn_i = 1'b0, bus_rst = 1'b0, susp = 1'b0, hpf = 1'b0, rvalid, wen;
    umr_bus_req_type req;
    umr_sof_type sof = '0;
    logic [23:0] rdata, d;
    logic [15:0] scr_o, nv;
    int fails = 0, num_checks = 0, m_scr = 0, m_frm = 0;
    integer seed = 32'h1cec;
    bit ok;
    umr_misc_regs DUT (.clk_i(clk_i), .rstn_i(rstn_i), .bus_reset_i(bus_rst), .suspend_i(susp),
        .host_powered_flag_i(hpf), .req_i(req), .sof_i(sof), .rdata_o(rdata), .rvalid_o(rvalid),
        .write_enable_o(wen), .scratch_o(scr_o));
    umr_fw_model fw (.clk_i(clk_i), .rvalid_i(rvalid), .rdata_i(rdata), .req_o(req));
    initial forever #25 clk_i = ~clk_i;
    task automatic wrap_up;
        if (fails == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h want %h", $time, seen, exp);
        end
    endtask : chk
    // a read that never answers ends the run
    task automatic rd(input logic [7:0] a, input logic bm, input logic [23:0] exp);
        fw.do_rd(a, bm, d, ok);
        if (!ok) begin
            fails++;
            wrap_up();
        end
        chk(d, exp);
    endtask : rd
    initial begin
        repeat (6) @(posedge clk_i);
        rstn_i <= 1'b1;
        rd(UMR_OFS_IDENTITY, 1'b0, {UMR_PART_ID_DEFAULT, UMR_VERSION_DEFAULT});
        fw.do_wr(UMR_OFS_IDENTITY, 16'hFFFF, 1'b0);
        rd(UMR_OFS_IDENTITY + 8'h1, 1'b1, {16'h0, UMR_PART_ID_DEFAULT[7:0]});
        rd(UMR_OFS_FRAME, 1'b0, 24'h0);
        rd(8'h60, 1'b0, 24'h0);
        repeat (3) begin
            m_scr = $random(seed);
            fw.do_wr(UMR_OFS_SCRATCH, m_scr[15:0], 1'b0);
            rd(UMR_OFS_SCRATCH, 1'b1, {16'h0, m_scr[7:0]});
            rd(UMR_OFS_SCRATCH + 8'h1, 1'b1, {16'h0, m_scr[15:8]});
            chk({8'h0, scr_o}, {8'h0, m_scr[15:0]});
        end
        // good sof, then fields move without valid
        repeat (2) begin
            m_frm = $random(seed) & 16'h3FFF;
            @(posedge clk_i);
            sof <= {1'b1, m_frm[13:0]};
            @(posedge clk_i);
            sof <= {1'b0, ~m_frm[13:0]};
            rd(UMR_OFS_FRAME, 1'b0, {8'h0, m_frm[15:0]});
        end
        rd(UMR_OFS_FRAME, 1'b1, {16'h0, m_frm[7:0]});
        @(posedge clk_i);
        sof.valid <= 1'b1;
        @(posedge clk_i);
        sof.valid <= 1'b0;
        rd(UMR_OFS_FRAME + 8'h1, 1'b1, {16'h0, m_frm[15:8]});
        rd(UMR_OFS_FRAME, 1'b0, {10'h0, ~m_frm[13:0]});
        @(posedge clk_i);
        bus_rst <= 1'b1;
        @(posedge clk_i);
        bus_rst <= 1'b0;
        rd(UMR_OFS_SCRATCH, 1'b0, 24'h0);
        rd(UMR_OFS_FRAME, 1'b0, 24'h0);
        // suspend with the flag set, then clear
        for (int p = 1; p >= 0; p--) begin
            @(posedge clk_i);
            susp <= 1'b0;
            hpf <= p[0];
            @(posedge clk_i);
            susp <= 1'b1;
            repeat (3) @(posedge clk_i);
            #1 chk({23'h0, wen}, {23'h0, p[0]});
            nv = 16'($random(seed));
            fw.do_wr(UMR_OFS_SCRATCH, nv, 1'b0);
            if (p == 1)
                m_scr = nv;
            rd(UMR_OFS_SCRATCH, 1'b0, {8'h0, m_scr[15:0]});
            fw.do_wr(UMR_OFS_UNLOCK, 16'h37AA, 1'b0);
            rd(UMR_OFS_UNLOCK, 1'b0, 24'h0);
            chk({23'h0, wen}, {23'h0, p[0]});
            fw.do_wr(UMR_OFS_UNLOCK, UMR_UNLOCK_KEY, 1'b0);
            @(posedge clk_i);
            #1 chk({23'h0, wen}, 24'h1);
        end
        @(posedge clk_i);
        susp <= 1'b0;
        @(posedge clk_i);
        susp <= 1'b1;
        repeat (3) @(posedge clk_i);
        fw.do_wr(UMR_OFS_UNLOCK, {8'h0, UMR_UNLOCK_KEY_LOW}, 1'b1);
        fw.do_wr(UMR_OFS_UNLOCK + 8'h1, {8'h0, UMR_UNLOCK_KEY_HIGH}, 1'b1);
        @(posedge clk_i);
        #1 chk({23'h0, wen}, 24'h1);
        wrap_up();
    end
endmodule : tb_usb_peripheral_misc_regs
